// file: atr_pkg.sv
package atr_pkg;
    localparam int ATR_AXES = 4;
    localparam int ATR_AXIS_W = 2;
    localparam logic [15:0] ATR_LINES_MIN = 16'h0001;
    localparam logic [15:0] ATR_LINES_MAX = 16'h3fff;
    localparam logic [15:0] ATR_LINES_RST = 16'h00c8;
    localparam logic [15:0] ATR_STEPS_MIN = 16'h0001;
    localparam logic [15:0] ATR_STEPS_MAX = 16'h7fff;
    localparam logic [15:0] ATR_STEPS_RST = 16'h00c8;
    localparam int ATR_LINES_LSB = 16;
    localparam int ATR_STEPS_LSB = 0;
    localparam logic [31:0] ATR_ACCEL_RST = 32'h0000_0001;
    localparam logic [31:0] ATR_SCALE_RST = 32'h0000_0001;
    localparam logic [31:0] ATR_OFFSET_RST = 32'h0000_0000;
    localparam logic [31:0] ATR_ROT_RST = 32'h0000_0000;
    localparam int ATR_CALC_MIN_MS = 1;
    localparam int ATR_CALC_MAX_MS = 100;
    localparam int ATR_CLK_MHZ = 100;
    localparam int ATR_CALC_CYCLES = ATR_CALC_MIN_MS * ATR_CLK_MHZ * 1000;
    localparam logic [32:0] ATR_SPAN_MAX = 33'h0_0020_0000;
    localparam logic [32:0] ATR_SPAN_MIN = 33'h1_ffe0_0000;

    typedef enum logic [3:0] {
        ATR_CMD_NONE = 4'h0,
        ATR_CMD_ACCEL = 4'h1,
        ATR_CMD_RES = 4'h2,
        ATR_CMD_TARGET = 4'h3,
        ATR_CMD_START = 4'h4,
        ATR_CMD_VEL = 4'h5,
        ATR_CMD_FACTOR = 4'h6
    } atr_cmd_e;

    typedef struct packed {
        atr_cmd_e cmd;
        logic [1:0] axis;
        logic [31:0] data;
    } atr_req_s;

    typedef struct packed {
        logic done;
        logic error;
    } atr_ack_s;
endpackage

// file: atr_target_math.sv
`timescale 1ns/10ps
`default_nettype none
module atr_target_math
    import atr_pkg::*;
(
    input wire logic signed [31:0] raw,
    input wire logic [31:0] scaleNum,
    input wire logic [31:0] scaleDen,
    input wire logic signed [31:0] offset,
    input wire logic [31:0] rotary,
    output logic signed [32:0] result
);
    logic signed [63:0] prod;
    logic signed [63:0] quot;
    logic signed [63:0] sum;
    logic signed [63:0] modv;

    always_comb
    begin
        prod = 64'(raw) * $signed({32'h0000_0000, scaleNum});
        quot = prod / $signed({32'h0000_0000, scaleDen});
        sum = quot + 64'(offset);
        modv = sum;
        if (rotary != 32'h0000_0000)
        begin
            modv = sum % $signed({32'h0000_0000, rotary});
            if (modv < 0)
            begin
                modv = modv + $signed({32'h0000_0000, rotary});
            end
        end
        result = modv[32:0];
    end
endmodule
`default_nettype wire

// file: atr_loader.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: Resolution word: lines high, steps low
// R2: Lines 1..16383, reset 200
// R3: Steps 1..32767, reset 200
// R4: Out-of-range resolution saturates, no error
// R5: Open-loop variant rejects resolution load
// R6: Host loads resolution before closed loop
// R7: Absolute target or relative distance
// R8: Host sets mode before target load
// R9: Target buffered, overwritten until start
// R10: New loads arm trajectory recalculation (code: target, velocity, accel and factor loads only)
// R11: Velocity mode uses target sign only
// R12: Host keeps stepper move within 2^21
// R13: Absolute span limit on move distance
// R14: Host keeps servo target in range
// R15: Scale and offset applied to target
// R16: Open loop steps, closed loop verifies
// R17: Acceleration clamped to supported maximum
// R18: Scale, offset, modulo, then counter
// R19: Start copies buffer to active target
module atr_loader
    import atr_pkg::*;
#(
    parameter logic [31:0] ACCEL_MAX = 32'h0000_ffff,
    parameter int CALC_CYCLES = ATR_CALC_CYCLES,
    parameter bit OPEN_LOOP_ONLY = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire atr_req_s req,
    input wire logic absMode,
    input wire logic velMode,
    input wire logic stepperAxis,
    input wire logic closedLoop,
    input wire logic [31:0] scaleNum,
    input wire logic [31:0] scaleDen,
    input wire logic signed [31:0] refOffset,
    input wire logic [31:0] rotaryCounts,
    input wire logic [ATR_AXES*32-1:0] presentPos,
    output atr_ack_s ack,
    output logic [ATR_AXES*16-1:0] encLines,
    output logic [ATR_AXES*16-1:0] motorSteps,
    output logic [ATR_AXES*32-1:0] accel,
    output logic [ATR_AXES*33-1:0] activeTarget,
    output logic [ATR_AXES-1:0] dirReverse,
    output logic [ATR_AXES-1:0] verifyEncoder,
    output logic [ATR_AXES-1:0] calcBusy,
    output logic [ATR_AXES-1:0] calcDone,
    output logic [ATR_AXES-1:0] startPulse
);
    logic signed [32:0] bufTarget [ATR_AXES];
    logic [ATR_AXES-1:0] bufRel;
    logic [ATR_AXES-1:0] bufVel;
    logic [31:0] calcCount [ATR_AXES];
    logic signed [32:0] mathOut;
    logic signed [32:0] absDest;
    logic signed [32:0] curPos;
    logic spanBad;

    function automatic logic [15:0] clampField(input logic [15:0] v, input logic [15:0] lo,
        input logic [15:0] hi);
        if (v < lo)
        begin
            return lo;
        end
        else if (v > hi)
        begin
            return hi;
        end
        return v;
    endfunction

    atr_target_math uMath (
        .raw(req.data), // R15 R18
        .scaleNum(scaleNum),
        .scaleDen(scaleDen),
        .offset(refOffset),
        .rotary(rotaryCounts),
        .result(mathOut)
    );

    // Absolute move distance check for steppers
    always_comb
    begin
        curPos = 33'(signed'(presentPos[req.axis*32 +: 32]));
        absDest = mathOut - curPos;
        spanBad = stepperAxis && absMode && !velMode &&
            (absDest > signed'(ATR_SPAN_MAX) || absDest < signed'(ATR_SPAN_MIN)); // R13
    end

    // Command acknowledge
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack <= '0;
        end
        else
        begin
            ack.done <= req.cmd != ATR_CMD_NONE;
            ack.error <= (req.cmd == ATR_CMD_RES && OPEN_LOOP_ONLY) || // R5
                (req.cmd == ATR_CMD_TARGET && spanBad); // R13
        end
    end

    // Resolution
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < ATR_AXES; i++)
            begin
                encLines[i*16 +: 16] <= ATR_LINES_RST; // R2
                motorSteps[i*16 +: 16] <= ATR_STEPS_RST; // R3
            end
        end
        else if (req.cmd == ATR_CMD_RES && !OPEN_LOOP_ONLY) // R5
        begin
            encLines[req.axis*16 +: 16] <= clampField(req.data[ATR_LINES_LSB +: 16],
                ATR_LINES_MIN, ATR_LINES_MAX); // R1 R2 R4
            motorSteps[req.axis*16 +: 16] <= clampField(req.data[ATR_STEPS_LSB +: 16],
                ATR_STEPS_MIN, ATR_STEPS_MAX); // R1 R3 R4
        end
    end

    // Acceleration
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            accel <= {ATR_AXES{ATR_ACCEL_RST}};
        end
        else if (req.cmd == ATR_CMD_ACCEL)
        begin
            accel[req.axis*32 +: 32] <= (req.data > ACCEL_MAX) ? ACCEL_MAX : req.data; // R17
        end
    end

    // Target buffer and start
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < ATR_AXES; i++)
            begin
                bufTarget[i] <= '0;
            end
            bufRel <= '0;
            bufVel <= '0;
            activeTarget <= '0;
            dirReverse <= '0;
            verifyEncoder <= '0;
            startPulse <= '0;
        end
        else
        begin
            startPulse <= '0;
            if (req.cmd == ATR_CMD_TARGET && !spanBad)
            begin
                bufTarget[req.axis] <= mathOut; // R9 R15
                bufRel[req.axis] <= !absMode; // R7 R8
                bufVel[req.axis] <= velMode;
            end
            if (req.cmd == ATR_CMD_START)
            begin
                startPulse[req.axis] <= 1'b1;
                verifyEncoder[req.axis] <= closedLoop && stepperAxis; // R16
                if (bufVel[req.axis])
                begin
                    dirReverse[req.axis] <= bufTarget[req.axis][32]; // R11
                end
                else
                begin
                    dirReverse[req.axis] <= bufTarget[req.axis][32];
                    activeTarget[req.axis*33 +: 33] <= bufRel[req.axis] ? // R7 R19
                        bufTarget[req.axis] + 33'(signed'(presentPos[req.axis*32 +: 32])) :
                        bufTarget[req.axis];
                end
            end
        end
    end

    // Trajectory recalculation timer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < ATR_AXES; i++)
            begin
                calcCount[i] <= '0;
            end
            calcBusy <= '0;
            calcDone <= '0;
        end
        else
        begin
            for (int i = 0; i < ATR_AXES; i++)
            begin
                if (req.axis == ATR_AXIS_W'(i) && (req.cmd == ATR_CMD_TARGET ||
                    req.cmd == ATR_CMD_VEL || req.cmd == ATR_CMD_ACCEL ||
                    req.cmd == ATR_CMD_FACTOR))
                begin
                    calcCount[i] <= 32'(CALC_CYCLES); // R10
                    calcBusy[i] <= 1'b1;
                    calcDone[i] <= 1'b0;
                end
                else if (calcCount[i] != 32'h0000_0000)
                begin
                    calcCount[i] <= calcCount[i] - 32'h0000_0001;
                    if (calcCount[i] == 32'h0000_0001)
                    begin
                        calcBusy[i] <= 1'b0;
                        calcDone[i] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: atr_loader_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module atr_loader_asserts
    import atr_pkg::*;
#(
    parameter logic [31:0] ACCEL_MAX = 32'h0000_ffff,
    parameter bit OPEN_LOOP_ONLY = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire atr_req_s req,
    input wire logic stepperAxis,
    input wire atr_ack_s ack,
    input wire logic [ATR_AXES*16-1:0] encLines,
    input wire logic [ATR_AXES*16-1:0] motorSteps,
    input wire logic [ATR_AXES*32-1:0] accel,
    input wire logic [ATR_AXES*33-1:0] activeTarget,
    input wire logic [ATR_AXES-1:0] calcBusy,
    input wire logic [ATR_AXES-1:0] startPulse
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire logic res0 = req.cmd == ATR_CMD_RES && req.axis == 2'h0;
    wire logic go0 = req.cmd == ATR_CMD_START && req.axis == 2'h0;
    a_done_follows: assert property (req.cmd != ATR_CMD_NONE |=> ack.done)
        else $error("done missing after command");
    a_lines_range: assert property (encLines[15:0] >= ATR_LINES_MIN &&
        encLines[15:0] <= ATR_LINES_MAX)
        else $error("lines out of range");
    a_steps_range: assert property (motorSteps[15:0] >= ATR_STEPS_MIN &&
        motorSteps[15:0] <= ATR_STEPS_MAX)
        else $error("steps out of range");
    a_res_error: assert property (res0 |=> ack.error == OPEN_LOOP_ONLY)
        else $error("resolution error flag wrong");
    a_steps_load: assert property (res0 && !OPEN_LOOP_ONLY && req.data[15:0] != 16'h0000 &&
        !req.data[15]
        |=> motorSteps[15:0] == $past(req.data[15:0]))
        else $error("steps field not loaded");
    a_target_buffered: assert property (req.cmd == ATR_CMD_TARGET |=> $stable(activeTarget))
        else $error("target acted on before start");
    a_start_pulse: assert property (go0 |=> startPulse[0])
        else $error("start pulse missing");
    a_pulse_cause: assert property (startPulse[0] |-> $past(go0))
        else $error("start pulse without start");
    a_busy_armed: assert property (req.cmd == ATR_CMD_TARGET && req.axis == 2'h0 && !stepperAxis
        |=> calcBusy[0])
        else $error("calculation not armed");
    a_accel_max: assert property (accel[31:0] <= ACCEL_MAX)
        else $error("acceleration above maximum");
    c_res: cover property (res0 ##1 ack.done);
    c_start: cover property (startPulse[0]);
    c_error: cover property (ack.error);
endmodule
`default_nettype wire

// file: atr_host.sv
`timescale 1ns/10ps
`default_nettype none
module atr_host
    import atr_pkg::*;
(
    input wire logic clk,
    output var atr_req_s req
);
    initial req = '{ATR_CMD_NONE, 2'h0, 32'h0};
    // One-cycle command strobe
    task automatic send(input atr_cmd_e c, input logic [1:0] a, input logic [31:0] d);
        @(negedge clk);
        req = '{c, a, d};
        @(negedge clk);
        req.cmd = ATR_CMD_NONE;
    endtask
endmodule
`default_nettype wire

// file: axis_target_and_resolution_loader_tb.sv
`timescale 1ns/10ps
`default_nettype none
module axis_target_and_resolution_loader_tb
    import atr_pkg::*;
;
    logic clk, rst_b, absMode, velMode, stepperAxis, closedLoop;
    logic [31:0] scaleNum, scaleDen, rotaryCounts;
    logic signed [31:0] refOffset;
    logic [127:0] presentPos, accel;
    atr_req_s req;
    atr_ack_s ack;
    logic [63:0] encLines, motorSteps;
    atr_ack_s ack2;
    logic [63:0] encLines2;
    logic [131:0] activeTarget;
    logic [3:0] dirReverse, verifyEncoder, calcBusy, calcDone, startPulse;
    int fails, tests_run, cyc;
    atr_host host (.clk(clk), .req(req));
    atr_loader #(.CALC_CYCLES(5)) DUT (.clk(clk), .rst_b(rst_b), .req(req), .absMode(absMode),
        .velMode(velMode), .stepperAxis(stepperAxis), .closedLoop(closedLoop),
        .scaleNum(scaleNum), .scaleDen(scaleDen), .refOffset(refOffset),
        .rotaryCounts(rotaryCounts), .presentPos(presentPos), .ack(ack), .encLines(encLines),
        .motorSteps(motorSteps), .accel(accel), .activeTarget(activeTarget),
        .dirReverse(dirReverse), .verifyEncoder(verifyEncoder), .calcBusy(calcBusy),
        .calcDone(calcDone), .startPulse(startPulse));
    atr_loader #(.CALC_CYCLES(5), .OPEN_LOOP_ONLY(1'b1)) DUT2 (.clk(clk), .rst_b(rst_b),
        .req(req), .absMode(absMode), .velMode(velMode), .stepperAxis(stepperAxis),
        .closedLoop(closedLoop), .scaleNum(scaleNum), .scaleDen(scaleDen), .refOffset(refOffset),
        .rotaryCounts(rotaryCounts), .presentPos(presentPos), .ack(ack2), .encLines(encLines2),
        .motorSteps(), .accel(), .activeTarget(), .dirReverse(), .verifyEncoder(), .calcBusy(),
        .calcDone(), .startPulse());
    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic go(input logic [31:0] d);
        host.send(ATR_CMD_TARGET, 2'h0, d);
        host.send(ATR_CMD_START, 2'h0, 32'h0);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            test_done;
        end
    end
    initial
    begin
        {rst_b, absMode, velMode, stepperAxis, closedLoop} = 5'h00;
        {scaleNum, scaleDen, refOffset, rotaryCounts} = {32'h1, 32'h1, 32'h0, 32'h0};
        presentPos = 128'h0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        chk("lines", 16'h00c8, encLines[15:0]);
        chk("steps", 16'h00c8, motorSteps[15:0]);
        host.send(ATR_CMD_RES, 2'h1, 32'h0032_07d0);
        chk("lines1", 16'h0032, encLines[31:16]);
        chk("steps1", 16'h07d0, motorSteps[31:16]);
        chk("olError", 1'b1, ack2.error);
        chk("olKept", 16'h00c8, encLines2[31:16]);
        host.send(ATR_CMD_RES, 2'h0, 32'hffff_0000);
        chk("error", 1'b0, ack.error);
        chk("linesHi", 16'h3fff, encLines[15:0]);
        chk("stepsLo", 16'h0001, motorSteps[15:0]);
        host.send(ATR_CMD_RES, 2'h0, 32'h0000_ffff);
        chk("linesLo", 16'h0001, encLines[15:0]);
        chk("stepsHi", 16'h7fff, motorSteps[15:0]);
        host.send(ATR_CMD_RES, 2'h0, 32'h0064_0190);
        chk("lines0", 16'h0064, encLines[15:0]);
        chk("steps0", 16'h0190, motorSteps[15:0]);
        host.send(ATR_CMD_ACCEL, 2'h0, 32'h0001_0000);
        chk("accel", 32'h0000_ffff, accel[31:0]);
        $display("test resolution done");
        absMode = 1'b1;
        closedLoop = 1'b1;
        host.send(ATR_CMD_TARGET, 2'h0, 32'h5);
        go(32'h9c40);
        chk("verify", 1'b0, verifyEncoder[0]);
        chk("buffer", 33'h9c40, activeTarget[32:0]);
        host.send(ATR_CMD_TARGET, 2'h0, 32'h7);
        chk("busy", 1'b1, calcBusy[0]);
        repeat (20) if (calcDone[0] !== 1'b1) @(negedge clk);
        chk("calc", 1'b1, calcDone[0]);
        chk("held", 33'h9c40, activeTarget[32:0]);
        absMode = 1'b0;
        presentPos[31:0] = 32'h2710;
        go(-32'sd10000);
        chk("relative", 33'h0, activeTarget[32:0]);
        {absMode, scaleNum, refOffset, rotaryCounts} = {1'b1, 32'h3, 32'h64, 32'h7d0};
        go(32'h4b0);
        chk("scaled", 33'h6a4, activeTarget[32:0]);
        {scaleNum, refOffset, rotaryCounts} = {32'h1, 32'h0, 32'h0};
        $display("test target done");
        {stepperAxis, velMode} = 2'h3;
        go(-32'sd1);
        chk("reverse", 1'b1, dirReverse[0]);
        chk("verifyStep", 1'b1, verifyEncoder[0]);
        go(32'h1);
        chk("forward", 1'b0, dirReverse[0]);
        velMode = 1'b0;
        presentPos[31:0] = 32'h0;
        host.send(ATR_CMD_TARGET, 2'h0, 32'h0030_0000);
        chk("spanErr", 1'b1, ack.error);
        host.send(ATR_CMD_TARGET, 2'h0, 32'h0020_0000);
        chk("spanOk", 1'b0, ack.error);
        $display("test stepper done");
        test_done;
    end
endmodule
bind atr_loader atr_loader_asserts #(.ACCEL_MAX(ACCEL_MAX), .OPEN_LOOP_ONLY(OPEN_LOOP_ONLY))
    chk_i (.clk(clk), .rst_b(rst_b),
    .req(req), .stepperAxis(stepperAxis), .ack(ack), .encLines(encLines),
    .motorSteps(motorSteps), .accel(accel), .activeTarget(activeTarget),
    .calcBusy(calcBusy), .startPulse(startPulse));
`default_nettype wire
